// file: pdmie_pkg.sv
// Constants of the microphone interface interrupt-enable and module-enable register bank.
// Assumes a 12-bit APB byte address and 32-bit data.
package pdmie_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_EVT_STARTED = 12'h100; // Transfer begun flag, read only
   localparam logic [ADDR_W-1:0] OFS_EVT_HALTED  = 12'h104; // Transfer halted flag, read only
   localparam logic [ADDR_W-1:0] OFS_EVT_LAST    = 12'h108; // Last sample written flag, read only
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 12'h110; // Sticky event status, write 1 clears
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 12'h300; // irq_enable_mask_reg, read-write
   localparam logic [ADDR_W-1:0] OFS_IRQ_SET     = 12'h304; // irq_enable_set_reg
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR     = 12'h308; // irq_enable_clear_reg
   localparam logic [ADDR_W-1:0] OFS_MODULE_ON   = 12'h500; // module_on_switch
   localparam logic [ADDR_W-1:0] OFS_CNT_LIMIT   = 12'h560; // sample_count_limit
   localparam logic [ADDR_W-1:0] OFS_CNT_VALUE   = 12'h564; // Samples stored so far, read only

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int NUM_EVT     = 3;
   localparam int BIT_STARTED = 0;
   localparam int BIT_HALTED  = 1;
   localparam int BIT_LAST    = 2;
   localparam int BIT_ON      = 0;
   localparam int CNT_W       = 15;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [NUM_EVT-1:0] MASK_RST  = 3'h0;
   localparam logic               ON_RST    = 1'h0;
   localparam logic [CNT_W-1:0]   LIMIT_RST = 15'h0000;
   localparam logic [CNT_W-1:0]   CNT_RST   = 15'h0000;

   // ************************************************************
   // Capture sequencing states
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DRAIN = 2'b10
   } pdmie_state_t;

endpackage

// file: pdmie_flag_if.sv
// Interface joining the register bank to one sticky event flag.
// Assumes the bank drives set and clear pulses in the pclk domain.
`timescale 1ns/1ps
interface pdmie_flag_if;
   logic set;  // Event pulse
   logic clr;  // Software clear pulse
   logic flag; // Sticky flag value

   modport owner (input set, input clr, output flag);
   modport user  (output set, output clr, input flag);
endinterface

// file: pdmie_flag.sv
// One sticky event flag: set by hardware, cleared by software, set wins.
// Assumes set and clr are single-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
module pdmie_flag
   import pdmie_pkg::*;
(
   input wire logic     pclk,    // System clock
   input wire logic     presetn, // Asynchronous reset, active low
   pdmie_flag_if.owner  fl       // Set, clear and flag value
);

   logic flag_ff;
   logic nxt_flag_ff;

   // Next flag value, an event in the clearing cycle is kept
   always_comb begin
      nxt_flag_ff = fl.set | (flag_ff & ~fl.clr);
   end

   // Flag register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag_ff;
      end
   end

   assign fl.flag = flag_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      fl.set |=> flag_ff)
      else $error("Event in clear cycle was lost");

endmodule

// file: pdmie_regs.sv
// Register bank of the microphone interface: interrupt enables, module switch, events.
// Assumes an APB master in the pclk domain and a capture datapath giving event pulses.
//
// Summary of operation
// - Set register bit0 enables transfer-begun interrupt
// - Set register bit1 enables halted, others kept
// - Set register bit2 enables last-sample interrupt
// - Clear register bit0 disables transfer-begun interrupt
// - Clear register bit1 disables halted, others kept
// - Clear register bit2 disables last-sample interrupt
// - Module switch bit: 1 on, 0 off
// - Module switch resets to zero, interface off
// - Plain mask register shows same three enables
// - Last-sample event after final or post-halt sample
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module pdmie_regs
   import pdmie_pkg::*;
(
   input  wire logic              pclk,          // System clock, 50 MHz
   input  wire logic              presetn,       // Asynchronous reset, active low
   input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
   input  wire logic              psel,          // APB select
   input  wire logic              penable,       // APB access phase
   input  wire logic              pwrite,        // APB write direction
   input  wire logic [DATA_W-1:0] pwdata,        // APB write data
   output logic       [DATA_W-1:0] prdata,       // APB read data
   output logic                    pready,       // APB ready
   output logic                    pslverr,      // APB error on unmapped address
   input  wire logic              xfer_begun,    // Datapath pulse: transfer has begun
   input  wire logic              xfer_halted,   // Datapath pulse: transfer has halted
   input  wire logic              halt_request,  // Pulse: halt requested by software
   input  wire logic              sample_stored, // Pulse: one sample written to memory
   output logic                    module_on,    // Microphone interface switched on
   output logic                    irq           // Interrupt, level, active high
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [NUM_EVT-1:0] mask_ff;
   logic [NUM_EVT-1:0] nxt_mask_ff;
   logic               on_ff;
   logic               nxt_on_ff;
   logic [CNT_W-1:0]   limit_ff;
   logic [CNT_W-1:0]   nxt_limit_ff;
   logic [CNT_W-1:0]   cnt_ff;
   logic [CNT_W-1:0]   nxt_cnt_ff;
   logic [DATA_W-1:0]  prdata_ff;
   logic [DATA_W-1:0]  nxt_prdata_ff;
   pdmie_state_t       state_ff;
   pdmie_state_t       nxt_state_ff;
   logic               last_evt;
   logic [CNT_W-1:0]   cnt_inc;
   logic [NUM_EVT-1:0] evt_set;
   logic [NUM_EVT-1:0] evt_clr;
   logic [NUM_EVT-1:0] status;
   logic               wr_acc;
   logic               rd_setup;
   logic               hit;
   logic [DATA_W-1:0]  rd_word;

   // ************************************************************
   // APB decode
   // ************************************************************

   // Write takes effect in the access cycle, read data is prepared in setup
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   // Address hit on any mapped register
   always_comb begin
      unique case (paddr)
         OFS_EVT_STARTED, OFS_EVT_HALTED, OFS_EVT_LAST, OFS_IRQ_STATUS,
         OFS_IRQ_MASK, OFS_IRQ_SET, OFS_IRQ_CLR, OFS_MODULE_ON,
         OFS_CNT_LIMIT, OFS_CNT_VALUE: hit = 1'b1;
         default:                       hit = 1'b0;
      endcase
   end

   // Zero wait states; error only in the access cycle of an unmapped address
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // ************************************************************
   // Read multiplexer
   // ************************************************************

   // Select the word for the addressed register, unused bits read zero
   always_comb begin
      rd_word = '0;
      unique case (paddr)
         OFS_EVT_STARTED: rd_word[0] = status[BIT_STARTED];
         OFS_EVT_HALTED:  rd_word[0] = status[BIT_HALTED];
         OFS_EVT_LAST:    rd_word[0] = status[BIT_LAST];
         OFS_IRQ_STATUS:  rd_word[NUM_EVT-1:0] = status;
         OFS_IRQ_MASK:    rd_word[NUM_EVT-1:0] = mask_ff;
         OFS_IRQ_SET:     rd_word[NUM_EVT-1:0] = mask_ff;
         OFS_IRQ_CLR:     rd_word[NUM_EVT-1:0] = mask_ff;
         OFS_MODULE_ON:   rd_word[BIT_ON] = on_ff;
         OFS_CNT_LIMIT:   rd_word[CNT_W-1:0] = limit_ff;
         OFS_CNT_VALUE:   rd_word[CNT_W-1:0] = cnt_ff;
         default:         rd_word = '0;
      endcase
   end

   // Read data register loads in the setup cycle, holds otherwise
   always_comb begin
      nxt_prdata_ff = prdata_ff;
      if (rd_setup) begin
         nxt_prdata_ff = rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else begin
         prdata_ff <= nxt_prdata_ff;
      end
   end

   assign prdata = prdata_ff;

   // ************************************************************
   // Interrupt enables and module switch
   // ************************************************************

   // Enable mask updated by plain, set and clear writes; zero bits of set and clear writes change nothing
   always_comb begin
      nxt_mask_ff = mask_ff;
      if (wr_acc && paddr == OFS_IRQ_MASK) begin
         nxt_mask_ff = pwdata[NUM_EVT-1:0];
      end else if (wr_acc && paddr == OFS_IRQ_SET) begin
         nxt_mask_ff = mask_ff | pwdata[NUM_EVT-1:0];
      end else if (wr_acc && paddr == OFS_IRQ_CLR) begin
         nxt_mask_ff = mask_ff & ~pwdata[NUM_EVT-1:0];
      end
   end

   // Module switch and sample count limit
   always_comb begin
      nxt_on_ff    = on_ff;
      nxt_limit_ff = limit_ff;
      if (wr_acc && paddr == OFS_MODULE_ON) begin
         nxt_on_ff = pwdata[BIT_ON];
      end
      if (wr_acc && paddr == OFS_CNT_LIMIT) begin
         nxt_limit_ff = pwdata[CNT_W-1:0];
      end
   end

   // Configuration registers, all clear at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff  <= MASK_RST;
         on_ff    <= ON_RST;
         limit_ff <= LIMIT_RST;
      end else begin
         mask_ff  <= nxt_mask_ff;
         on_ff    <= nxt_on_ff;
         limit_ff <= nxt_limit_ff;
      end
   end

   assign module_on = on_ff;

   // ************************************************************
   // Capture sequencing
   // ************************************************************

   assign cnt_inc = cnt_ff + 15'h0001;

   // Track stored samples, raise last-sample event at the limit or after a halt
   always_comb begin
      nxt_state_ff = state_ff;
      nxt_cnt_ff   = cnt_ff;
      last_evt     = 1'b0;
      if (!on_ff) begin
         nxt_state_ff = ST_IDLE;
         nxt_cnt_ff   = CNT_RST;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (xfer_begun) begin
                  nxt_state_ff = ST_RUN;
                  nxt_cnt_ff   = CNT_RST;
               end
            end
            ST_RUN: begin
               if (sample_stored) begin
                  nxt_cnt_ff = cnt_inc;
                  if (cnt_inc == limit_ff) begin
                     last_evt     = 1'b1;
                     nxt_state_ff = ST_IDLE;
                  end else if (halt_request) begin
                     nxt_state_ff = ST_DRAIN;
                  end
               end else if (halt_request) begin
                  nxt_state_ff = ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (sample_stored) begin
                  nxt_cnt_ff   = cnt_inc;
                  last_evt     = 1'b1;
                  nxt_state_ff = ST_IDLE;
               end
            end
            default: begin
               nxt_state_ff = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= CNT_RST;
      end else begin
         state_ff <= nxt_state_ff;
         cnt_ff   <= nxt_cnt_ff;
      end
   end

   // ************************************************************
   // Sticky event flags and interrupt
   // ************************************************************

   // Event pulses and write-one clears of the status register
   assign evt_set[BIT_STARTED] = xfer_begun & on_ff;
   assign evt_set[BIT_HALTED]  = xfer_halted & on_ff;
   assign evt_set[BIT_LAST]    = last_evt;
   assign evt_clr = (wr_acc && paddr == OFS_IRQ_STATUS) ? pwdata[NUM_EVT-1:0] : '0;

   pdmie_flag_if evt_if [NUM_EVT] ();

   // One sticky flag per event
   for (genvar gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      assign evt_if[gi].set = evt_set[gi];
      assign evt_if[gi].clr = evt_clr[gi];
      assign status[gi]     = evt_if[gi].flag;
      pdmie_flag u_flag (
         .pclk    (pclk),
         .presetn (presetn),
         .fl      (evt_if[gi])
      );
   end

   // Level interrupt while any enabled flag stands
   assign irq = |(status & mask_ff);

   // ************************************************************
   // Assertions
   // ************************************************************
   a_set_begun_on: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_SET && pwdata[BIT_STARTED] |=> mask_ff[BIT_STARTED])
      else $error("Set write did not enable transfer-begun");

   a_set_halted_only: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_SET && pwdata[2:0] == 3'h2
      |=> mask_ff[BIT_HALTED] && mask_ff[BIT_STARTED] == $past(mask_ff[BIT_STARTED])
          && mask_ff[BIT_LAST] == $past(mask_ff[BIT_LAST]))
      else $error("Set write of halted disturbed other enables");

   a_set_last_read: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_SET && pwdata[BIT_LAST]
      ##2 rd_setup && paddr == OFS_IRQ_SET |=> prdata[BIT_LAST])
      else $error("Set register did not read back last-sample enable");

   a_clr_begun_off: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_CLR && pwdata[BIT_STARTED] |=> !mask_ff[BIT_STARTED])
      else $error("Clear write did not disable transfer-begun");

   a_clr_halted_only: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_CLR && pwdata[2:0] == 3'h2
      |=> !mask_ff[BIT_HALTED] && mask_ff[BIT_STARTED] == $past(mask_ff[BIT_STARTED])
          && mask_ff[BIT_LAST] == $past(mask_ff[BIT_LAST]))
      else $error("Clear write of halted disturbed other enables");

   a_clr_last_read: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_CLR && pwdata[BIT_LAST]
      ##2 rd_setup && (paddr == OFS_IRQ_CLR || paddr == OFS_IRQ_SET) |=> !prdata[BIT_LAST])
      else $error("Clear register did not read back disabled");

   a_on_follows_wr: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_MODULE_ON |=> module_on == $past(pwdata[BIT_ON]))
      else $error("Module switch does not follow write");

   a_on_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !module_on)
      else $error("Module switch not off after reset");

   a_mask_read_same: assert property (@(posedge pclk) disable iff (!presetn)
      rd_setup && paddr == OFS_IRQ_MASK |=> prdata[NUM_EVT-1:0] == $past(mask_ff))
      else $error("Mask register read differs from enables");

   a_last_at_limit: assert property (@(posedge pclk) disable iff (!presetn)
      on_ff && state_ff == ST_RUN && sample_stored && cnt_inc == limit_ff
      |=> status[BIT_LAST] && state_ff == ST_IDLE)
      else $error("Last-sample event missing at count limit");

   a_zero_set_noop: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && (paddr == OFS_IRQ_SET || paddr == OFS_IRQ_CLR) && pwdata[2:0] == 3'h0
      |=> $stable(mask_ff))
      else $error("Zero write to set or clear changed enables");

   a_irq_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_CLR && pwdata[2:0] == 3'h7 |=> !irq)
      else $error("Interrupt stands with all enables cleared");

   c_last_by_halt: cover property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_DRAIN ##[1:50] status[BIT_LAST]);

   c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));

   c_set_then_clr: cover property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == OFS_IRQ_SET ##[1:10] wr_acc && paddr == OFS_IRQ_CLR);

endmodule

// file: tb_top.sv
// Self-checking testbench of the interrupt-enable and module-switch register bank.
// Assumes pdmie_pkg and pdmie_regs compiled first; APB master and event pulses from here.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
   import pdmie_pkg::*;

   // ************************************************************
   // Signals and counters
   // ************************************************************
   logic              pclk;
   logic              presetn;
   logic [ADDR_W-1:0] paddr;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic [3:0]        ev;
   logic              module_on;
   logic              irq;
   logic [31:0]       seed;
   logic [2:0]        mask_m;
   int                err_count;
   int                checks;

   // Clock at 50 MHz
   always #10 pclk = ~pclk;

   pdmie_regs u_pdmie_regs (
      .pclk          (pclk),
      .presetn       (presetn),
      .paddr         (paddr),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .xfer_begun    (ev[0]),
      .xfer_halted   (ev[1]),
      .halt_request  (ev[2]),
      .sample_stored (ev[3]),
      .module_on     (module_on),
      .irq           (irq)
   );

   // ************************************************************
   // Helpers
   // ************************************************************
   // Xorshift step, repeatable from the fixed seed
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // One APB transfer, entered just after a rising edge; waits for pready
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   // Read and compare with an expected word
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, exp)
   endtask

   // Single-cycle pulse on one event input, then let the bank settle
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic end_of_test();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [31:0] r;
      logic        e;
      logic [31:0] d;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ev = 4'h0;
      seed = 32'hebe2;
      mask_m = 3'h0;
      err_count = 0;
      checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values
      `CHK(module_on, 1'b0)
      rdchk(OFS_MODULE_ON, 32'h0);
      rdchk(OFS_IRQ_MASK, 32'h0);
      rdchk(OFS_IRQ_SET, 32'h0);
      rdchk(OFS_IRQ_CLR, 32'h0);
      // Random set, clear and plain mask writes, zeros among them
      for (int k = 0; k < 60; k++) begin
         seed = xs(seed);
         d = (k % 7 == 0) ? 32'h0 : xs(seed ^ 32'h5a5a);
         case (seed[1:0])
            2'h0: begin
               wr(OFS_IRQ_MASK, d);
               mask_m = d[2:0];
            end
            2'h1, 2'h3: begin
               wr(OFS_IRQ_SET, d);
               mask_m = mask_m | d[2:0];
            end
            default: begin
               wr(OFS_IRQ_CLR, d);
               mask_m = mask_m & ~d[2:0];
            end
         endcase
         rdchk(OFS_IRQ_SET, {29'h0, mask_m});
         rdchk(OFS_IRQ_CLR, {29'h0, mask_m});
         rdchk(OFS_IRQ_MASK, {29'h0, mask_m});
      end
      // Unmapped address refused
      apb(1'b0, 12'h7fc, 32'h0, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0)
      // Module switch on
      wr(OFS_MODULE_ON, 32'hffffffff);
      `CHK(module_on, 1'b1)
      rdchk(OFS_MODULE_ON, 32'h1);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_IRQ_STATUS, 32'h7);
      // Transfer-begun event, enabled then disabled
      pulse(0);
      rdchk(OFS_IRQ_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_SET, 32'h1);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLR, 32'h6);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLR, 32'h0);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLR, 32'h1);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_STATUS, 32'h7);
      // Transfer-halted event
      pulse(1);
      wr(OFS_IRQ_SET, 32'h2);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLR, 32'h2);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_STATUS, 32'h7);
      // Last sample at the programmed count
      wr(OFS_CNT_LIMIT, 32'h3);
      wr(OFS_IRQ_SET, 32'h4);
      pulse(0);
      wr(OFS_IRQ_STATUS, 32'h1);
      pulse(3);
      pulse(3);
      `CHK(irq, 1'b0)
      pulse(3);
      `CHK(irq, 1'b1)
      rdchk(OFS_IRQ_STATUS, 32'h4);
      rdchk(OFS_EVT_LAST, 32'h1);
      wr(OFS_IRQ_STATUS, 32'h7);
      // Last sample after a halt request
      pulse(0);
      wr(OFS_IRQ_STATUS, 32'h1);
      pulse(2);
      `CHK(irq, 1'b0)
      pulse(3);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLR, 32'h4);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_STATUS, 32'h7);
      // Module switched off: events no longer recorded
      wr(OFS_MODULE_ON, 32'hfffffffe);
      `CHK(module_on, 1'b0)
      rdchk(OFS_MODULE_ON, 32'h0);
      pulse(0);
      rdchk(OFS_IRQ_STATUS, 32'h0);
      end_of_test();
   end
endmodule
